// *** tb/rtc_chk_sva.sv ***
// rtc_chk_sva: bus, wake and event pulse checks on the counter's pins
// assumes bind onto real_time_counter_calendar, hready looped back
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module rtc_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        wake_in,
	input wire logic        irq,
	input wire logic        wake_req,
	input wire logic [7:0]  periodic_tap_event_out,
	input wire logic        alarm_event_out,
	input wire logic        tamper_event_out,
	input wire logic        overflow_event_out
);
	logic [15:0] gap_q;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// cycles since the last tap 0 pulse, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			gap_q <= 16'hFFFF;
		else if (periodic_tap_event_out[0])
			gap_q <= 16'h0000;
		else if (gap_q != 16'hFFFF)
			gap_q <= gap_q + 16'h0001;
	end

	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_rdata_hold: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	a_wake_input: assert property (wake_in |=> wake_req)
		else $error("wake input did not raise wake");
	a_wake_irq: assert property (irq ##1 irq |-> wake_req)
		else $error("interrupt without wake");
	a_tap_pulse: assert property (|periodic_tap_event_out |=> periodic_tap_event_out == 8'h00)
		else $error("tap event longer than one cycle");
	// tap 0 rises at most once per source tick
	a_tap_spacing: assert property (periodic_tap_event_out[0] |-> gap_q >= 16'(`SRC_DIV))
		else $error("tap events too close");
	a_alarm_pulse: assert property (alarm_event_out |=> !alarm_event_out)
		else $error("alarm event longer than one cycle");
	a_ovf_pulse: assert property (overflow_event_out |=> !overflow_event_out)
		else $error("overflow event longer than one cycle");
	a_tamper_pulse: assert property ($rose(tamper_event_out) |=> $fell(tamper_event_out))
		else $error("tamper event longer than one cycle");
endmodule : rtc_chk

bind real_time_counter_calendar rtc_chk chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite,
	.hreadyout, .hrdata, .hresp, .wake_in, .irq, .wake_req, .periodic_tap_event_out,
	.alarm_event_out, .tamper_event_out, .overflow_event_out);
`default_nettype wire

// *** tb/test_real_time_counter_calendar.sv ***
// test_real_time_counter_calendar: registers, counting, events, calendar
// assumes a 100 MHz hclk and hready looped from the slave's hreadyout
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module test_real_time_counter_calendar;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        wake_in = 1'b0;
	logic        tamper_event_in = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] seed = 32'h0000005E;
	logic [31:0] hrdata, rd, v;
	logic        hready, hresp, irq, wake_req;
	logic        alarm_event_out, tamper_event_out, overflow_event_out, compare1_event_out;
	logic [7:0]  tap;
	logic [4:0]  ev;
	logic [4:0]  tamper_in = 5'h00;
	logic [31:0] st [3], ex [3], cw [3];
	int          failures = 0, num_checks = 0, i, c;

	real_time_counter_calendar dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp, .wake_in,
		.dbg_halt(1'b0), .tamper_in, .tamper_event_in, .irq, .wake_req,
		.periodic_tap_event_out(tap), .alarm_event_out, .compare1_event_out,
		.tamper_event_out, .overflow_event_out);

	// event lines polled by index
	assign ev = {compare1_event_out, tamper_event_out, overflow_event_out, alarm_event_out,
		tap[0]};

	always #5 hclk = ~hclk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// packed calendar time: year, month, day, hour, minute, second
	function automatic logic [31:0] cal(input int y, mo, d, h, mi, s);
		return {6'(y), 4'(mo), 5'(d), 5'(h), 6'(mi), 6'(s)};
	endfunction : cal

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one single transfer; the master never assumes a wait count
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rc

	// poll the busy flags until a pending write has landed
	task automatic settle();
		int j;
		rd = 32'h1;
		for (j = 0; j < 2000 && rd !== 32'h0; j++)
			bus(1'b0, 32'h040, 32'h0);
		chk(rd, 32'h0);
	endtask : settle

	// sampled at falling edges so one-cycle pulses are settled
	task automatic wait_ev(input int k, input int n, output int cnt);
		cnt = 0;
		do begin
			@(negedge hclk);
			cnt++;
		end while (ev[k] !== 1'b1 && cnt < n);
		chk({31'h0, ev[k]}, 32'h1);
		cnt = cnt - 1;
		@(posedge hclk);
	endtask : wait_ev

	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// watchdog at 100000 cycles, a quarter beyond the expected run of about 80000 cycles
	initial begin
		#1000000;
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		finish_test();
	end

	initial begin
		st[0] = cal(4, 2, 28, 23, 59, 59);
		ex[0] = cal(4, 2, 29, 0, 0, 0);
		st[1] = cal(5, 2, 28, 23, 59, 59);
		ex[1] = cal(5, 3, 1, 0, 0, 0);
		st[2] = cal(5, 6, 30, 11, 59, 59);
		ex[2] = cal(5, 6, 30, 28, 0, 0);
		cw[0] = 32'h0000000A;
		cw[1] = 32'h0000000A;
		cw[2] = 32'h0000004A;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		wake_in <= 1'b1;
		rc(32'h060, 32'h0);
		wake_in <= 1'b0;
		// random general purpose data, unmapped place
		for (i = 0; i < 4; i++) begin
			v = rnd();
			wr(32'h100 + 32'(i % 2) * 32'h10, v);
			rc(32'h100 + 32'(i % 2) * 32'h10, v);
		end
		wr(32'h1F0, rnd());
		rc(32'h1F0, 32'h0);
		// set and clear of enables, zero ignored
		wr(32'h028, 32'h8100);
		wr(32'h020, 32'h0);
		rc(32'h028, 32'h8100);
		wr(32'h020, 32'h8100);
		rc(32'h028, 32'h0);
		wr(32'h028, 32'h8100);
		// count write pends until a source tick
		wr(32'h060, 32'hFFFFFFFE);
		wr(32'h050, 32'h00000080);
		rc(32'h040, 32'hC);
		settle();
		rc(32'h060, 32'hFFFFFFFE);
		rc(32'h050, 32'h80);
		// tamper event stamps the stopped count
		wr(32'h010, 32'h0001C3FF);
		tamper_event_in <= 1'b1;
		@(posedge hclk);
		tamper_event_in <= 1'b0;
		wait_ev(3, 4000, c);
		// a pin needs three source ticks to pass the debounce
		tamper_in <= 5'(rnd()) | 5'h01;
		wait_ev(3, 12000, c);
		tamper_in <= 5'h00;
		rc(32'h190, 32'hFFFFFFFE);
		rc(32'h030, 32'h4000);
		wr(32'h030, 32'h4000);
		rc(32'h030, 32'h0);
		wr(32'h080, 32'hFFFFFFFE);
		wr(32'h000, 32'h2);
		wait_ev(1, 12000, c);
		rc(32'h060, 32'hFFFFFFFF);
		wait_ev(2, 4000, c);
		rc(32'h060, 32'h0);
		bus(1'b0, 32'h030, 32'h0);
		chk(rd & 32'h8100, 32'h8100);
		chk({31'h0, irq}, 32'h1);
		wr(32'h030, 32'hFFFF);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		// clear on match gives a three tick period
		wr(32'h080, 32'h2);
		wr(32'h000, 32'h82);
		wait_ev(1, 12000, c);
		wait_ev(1, 12000, c);
		chk(32'(c), 32'(3 * `SRC_DIV - 1));
		rc(32'h060, 32'h0);
		// tap 0 follows prescaler bit 0
		wait_ev(0, 7000, c);
		wait_ev(0, 7000, c);
		chk(32'(c), 32'(2 * `SRC_DIV - 1));
		// 16-bit mode: compare1 at 1, compare0 low half at 2
		wr(32'h060, 32'h0);
		settle();
		wr(32'h088, 32'h1);
		wr(32'h000, 32'h6);
		wait_ev(4, 12000, c);
		rc(32'h060, 32'h2);
		wait_ev(1, 4000, c);
		// calendar steps across day, leap and noon
		for (i = 0; i < 3; i++) begin
			wr(32'h000, cw[i]);
			wr(32'h060, st[i]);
			settle();
			rc(32'h060, st[i]);
			for (c = 0; c < 2000 && rd === st[i]; c++)
				bus(1'b0, 32'h060, 32'h0);
			chk(rd, ex[i]);
		end
		finish_test();
	end
endmodule : test_real_time_counter_calendar
`default_nettype wire

// *** verilog/cal_if.sv ***
// cal_if: current calendar time out to the stepper, next time back
// assumes one instance per counter block, purely combinational
`timescale 1ns/10ps
`default_nettype none
interface cal_if;
	logic [31:0] time_now;
	logic        h12;
	logic [31:0] time_next;
	logic        wrap;
	modport user (output time_now, output h12, input time_next, input wrap);
	modport step (input time_now, input h12, output time_next, output wrap);
endinterface : cal_if
`default_nettype wire

// *** verilog/calendar_step.sv ***
// calendar_step: next second of a packed calendar time
// assumes years count from a leap year, so year mod 4 == 0 is a leap year
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module calendar_step (
	cal_if.step bus
);
	logic [5:0] sec, mi, yr;
	logic [4:0] hr, dy, dim;
	logic [3:0] mo;
	logic       roll;

	// RULE8: seconds minutes hours
	// RULE9: date with leap year
	always_comb begin
		sec  = bus.time_now[`CAL_MIN_LSB-1:0];
		mi   = bus.time_now[`CAL_HR_LSB-1:`CAL_MIN_LSB];
		hr   = bus.time_now[`CAL_DAY_LSB-1:`CAL_HR_LSB];
		dy   = bus.time_now[`CAL_MON_LSB-1:`CAL_DAY_LSB];
		mo   = bus.time_now[`CAL_YR_LSB-1:`CAL_MON_LSB];
		yr   = bus.time_now[31:`CAL_YR_LSB];
		roll = 1'b0;
		bus.wrap = 1'b0;
		case (mo)
			`CAL_FEB: dim = (yr[1:0] == 2'h0) ? `CAL_D29 : `CAL_D28;
			`CAL_APR, `CAL_JUN, `CAL_SEP, `CAL_NOV: dim = `CAL_D30;
			default: dim = `CAL_D31;
		endcase
		if (sec != `CAL_SEC_MAX) begin
			sec = sec + 6'h1;
		end else begin
			sec = 6'h0;
			if (mi != `CAL_SEC_MAX) begin
				mi = mi + 6'h1;
			end else begin
				mi = 6'h0;
				// 12 h: bit 4 is pm, hours run 12,1..11
				if (bus.h12) begin
					if (hr[3:0] == `CAL_HR12_TOP) begin
						hr[3:0] = 4'h1;
					end else if (hr[3:0] == `CAL_HR12_PM) begin
						hr[3:0] = `CAL_HR12_TOP;
						roll    = hr[4];
						hr[4]   = ~hr[4];
					end else begin
						hr[3:0] = hr[3:0] + 4'h1;
					end
				end else if (hr == `CAL_HR24_MAX) begin
					hr   = 5'h0;
					roll = 1'b1;
				end else begin
					hr = hr + 5'h1;
				end
			end
		end
		// day, month, year carry
		if (roll) begin
			if (dy >= dim) begin
				dy = 5'h1;
				if (mo >= `CAL_MON_MAX) begin
					mo       = 4'h1;
					bus.wrap = &yr;
					yr       = yr + 6'h1;
				end else begin
					mo = mo + 4'h1;
				end
			end else begin
				dy = dy + 5'h1;
			end
		end
		bus.time_next = {yr, mo, dy, hr, mi, sec};
	end
endmodule : calendar_step
`default_nettype wire

// *** verilog/real_time_counter_calendar.sv ***
// real_time_counter_calendar: 32/16-bit counter and calendar behind AHB-Lite
// assumes a single slave on the bus, whole-word transfers, synchronous pins
// Behaviour
// RULE1: 32-bit counter ticked by 10-bit prescaler
// RULE2: wake request on match, tap, overflow, input
// RULE3: eight prescaler taps with enable and flag
// RULE4: compare match raises flag and event
// RULE5: counter wrap raises overflow flag, event
// RULE6: optional clear of counter on match
// RULE7: 32-bit mode one compare, 16-bit two
// RULE8: calendar seconds, minutes, hours, 12/24
// RULE9: calendar day, month, year, leap years
// RULE10: signed prescaler correction, sign bit 7
// RULE11: two general purpose 32-bit registers
// RULE12: tamper captures timestamp and flags interrupt
// RULE13: counter readable/writable at 0x18, resets zero
// RULE14: mode field 0 selects 32-bit count
// RULE15: mode field 2 selects clock/calendar
// RULE16: enable set/clear registers, zero ignored
// RULE17: busy bit high while write pends
// RULE18: write one clears flag; enabled flag interrupts
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module real_time_counter_calendar (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic [31:0] hrdata,
	output var  logic        hresp,
	input  wire logic        wake_in,
	input  wire logic        dbg_halt,
	input  wire logic [4:0]  tamper_in,
	input  wire logic        tamper_event_in,
	output var  logic        irq,
	output var  logic        wake_req,
	output var  logic [7:0]  periodic_tap_event_out,
	output var  logic        alarm_event_out,
	output var  logic        compare1_event_out,
	output var  logic        tamper_event_out,
	output var  logic        overflow_event_out
);
	rtc_pkg::state_t s, n;
	rtc_pkg::mode_t  mode;
	cal_if           cal ();

	logic        src, run, tick, ovf, m0, m1, tamper, wr, rd, mclr;
	logic [1:0]  adv;
	logic [9:0]  pnext;
	logic [3:0]  psel;
	logic [4:0]  tnew, trise;
	logic [31:0] cmask, clr;
	logic [15:0] evs;
	logic [32:0] inc;

	// calendar arithmetic lives in its own module
	assign cal.time_now = s.count;
	assign cal.h12      = s.ctrl_a[`CA_CLKREP];

	calendar_step u_cal (
		.bus (cal.step)
	);

	// outputs straight from the state flops, hresp tied low
	assign hreadyout              = s.rdy;
	assign hrdata                 = s.rdata;
	assign hresp                  = 1'b0;
	assign irq                    = s.irq;
	assign wake_req               = s.wake;
	assign periodic_tap_event_out = s.ev[7:0];
	assign alarm_event_out        = s.ev[8];
	assign compare1_event_out     = s.ev[9];
	assign tamper_event_out       = s.ev[10];
	assign overflow_event_out     = s.ev[11];

	// next-state logic for the whole block
	always_comb begin
		n     = s;
		mode  = rtc_pkg::mode_t'(s.ctrl_a[`CA_MODE +: 2]);
		mclr  = s.ctrl_a[`CA_MCLR];
		ovf   = 1'b0;
		m0    = 1'b0;
		m1    = 1'b0;
		tick  = 1'b0;
		cmask = 32'h0;
		clr   = 32'h0;
		inc   = 33'h0;

		// source tick divider from hclk
		src       = (s.src_cnt == 12'(`SRC_DIV - 1));
		n.src_cnt = src ? 12'h0 : s.src_cnt + 12'h1;
		run       = s.ctrl_a[`CA_EN] && !(dbg_halt && !s.run_while_halted);

		// RULE10: signed rate correction
		adv = 2'h1;
		if (s.cw < s.rate_correction[`CORR_W-1:0]) begin
			adv = s.rate_correction[`FC_SIGN] ? 2'h0 : 2'h2;
		end
		if (src) begin
			n.cw = s.cw + 7'h1;
		end

		// RULE1: prescaler divides source
		pnext = s.psc + {8'h0, adv};
		if (src && run) begin
			n.psc = pnext;
		end
		psel = (s.ctrl_a[`CA_PSC +: 4] > `PSC_MAX) ? `PSC_MAX : s.ctrl_a[`CA_PSC +: 4];
		if (src && run) begin
			tick = (psel == 4'h0) ? 1'b1 : (s.psc[psel - 4'h1] & ~pnext[psel - 4'h1]);
		end

		// RULE7: compare per counting mode
		case (mode)
			rtc_pkg::MODE_FULL_WIDTH_COUNT_MODE: begin
				m0 = tick && (s.count == s.comp0);
			end
			rtc_pkg::MODE_COUNT16: begin
				m0 = tick && (s.count[15:0] == s.comp0[15:0]);
				m1 = tick && (s.count[15:0] == s.comp1);
			end
			rtc_pkg::MODE_CALENDAR: begin
				// alarm compares only the fields the mask selects
				case (s.mask)
					3'h1: cmask = 32'((33'h1 << `CAL_MIN_LSB) - 33'h1);
					3'h2: cmask = 32'((33'h1 << `CAL_HR_LSB) - 33'h1);
					3'h3: cmask = 32'((33'h1 << `CAL_DAY_LSB) - 33'h1);
					3'h4: cmask = 32'((33'h1 << `CAL_MON_LSB) - 33'h1);
					3'h5: cmask = 32'((33'h1 << `CAL_YR_LSB) - 33'h1);
					3'h6: cmask = 32'hFFFFFFFF;
					default: cmask = 32'h0;
				endcase
				m0 = tick && (cmask != 32'h0) && (((s.count ^ s.comp0) & cmask) == 32'h0);
			end
			default: begin
				m0 = 1'b0;
			end
		endcase

		// counter advance
		if (tick) begin
			case (mode)
				// RULE14: plain 32-bit count
				rtc_pkg::MODE_FULL_WIDTH_COUNT_MODE: begin
					inc     = {1'b0, s.count} + 33'h1;
					n.count = inc[31:0];
					ovf     = inc[32];
				end
				rtc_pkg::MODE_COUNT16: begin
					inc     = {17'h0, s.count[15:0]} + 33'h1;
					n.count = {16'h0, inc[15:0]};
					ovf     = inc[16];
				end
				// RULE15: calendar replaces count
				rtc_pkg::MODE_CALENDAR: begin
					n.count = cal.time_next;
					ovf     = cal.wrap;
				end
				default: begin
					n.count = s.count;
				end
			endcase
			// RULE6: clear on match
			if (mclr && (m0 || m1) && (mode != rtc_pkg::MODE_CALENDAR)) begin
				n.count = 32'h0;
			end
		end

		// RULE17: pending writes land on a source tick
		if (src) begin
			if (s.cnt_pend) begin
				n.count    = s.cnt_new;
				n.cnt_pend = 1'b0;
			end
			if (s.en_pend) begin
				n.ctrl_a[`CA_EN] = s.en_new;
				n.en_pend        = 1'b0;
			end
			if (s.fc_pend) begin
				n.rate_correction = s.fc_new;
				n.fc_pend  = 1'b0;
			end
		end

		// tamper inputs: two equal samples on source ticks
		tnew = s.tdb;
		if (src) begin
			n.tp0 = tamper_in;
			n.tp1 = s.tp0;
			tnew  = (s.tp0 & s.tp1) | (s.tdb & (s.tp0 | s.tp1));
			n.tdb = tnew;
		end
		trise  = tnew & ~s.tdb;
		tamper = (|trise) || (tamper_event_in && s.event_output_control[`EV_TEI]);

		// RULE12: timestamp on tamper
		if (tamper) begin
			n.stamp = s.count;
			if (s.ctrl_a[`CA_GP_RESET_ON_TAMPER]) begin
				n.gp0 = 32'h0;
				n.gp1 = 32'h0;
			end
		end

		// RULE3: taps from prescaler rising bits
		// RULE4: compare flag
		// RULE5: overflow flag
		evs              = 16'h0;
		evs[7:0]         = (src && run) ? (pnext[7:0] & ~s.psc[7:0]) : 8'h0;
		evs[`EV_CMP0]    = m0;
		evs[`EV_CMP1]    = m1;
		evs[`EV_TAMP]    = tamper;
		evs[`EV_OVF]     = ovf;

		// bus data phase write
		wr = s.a_valid && s.a_write && s.a_ok;
		if (wr) begin
			case (s.a_idx)
				`IDX_CTRL_A: begin
					n.ctrl_a         = hwdata[15:0];
					n.ctrl_a[`CA_EN] = s.ctrl_a[`CA_EN];
					n.en_pend        = 1'b1;
					n.en_new         = hwdata[`CA_EN];
				end
				`IDX_CTRL_B: n.ctrl_b = hwdata[15:0];
				`IDX_EVENT_OUTPUT_CONTROL: n.event_output_control = hwdata;
				// RULE16: set and clear of enables
				`IDX_IEN_CLR: n.inten = s.inten & ~hwdata[15:0];
				`IDX_IEN_SET: n.inten = s.inten | hwdata[15:0];
				`IDX_FLAGS: clr = hwdata;
				`IDX_DBG: n.run_while_halted = hwdata[0];
				// RULE17: busy raised on write
				`IDX_RATE_CORRECTION: begin
					n.fc_pend = 1'b1;
					n.fc_new  = hwdata[7:0];
				end
				// RULE13: counter write via pending
				`IDX_COUNT: begin
					n.cnt_pend = 1'b1;
					n.cnt_new  = hwdata;
				end
				`IDX_COMP0: n.comp0 = hwdata;
				`IDX_COMP1: n.comp1 = hwdata[15:0];
				`IDX_MASK: n.mask = hwdata[2:0];
				// RULE11: general purpose words
				`IDX_GP0: n.gp0 = hwdata;
				`IDX_GP1: n.gp1 = hwdata;
				default: n.mask = n.mask;
			endcase
		end

		// RULE18: write one clears, set wins
		n.flags = (s.flags & ~clr[15:0]) | evs;

		// soft reset keeps debug control and the source tick divider
		if (wr && (s.a_idx == `IDX_CTRL_A) && hwdata[`CA_SOFT_RESET]) begin
			n          = '0;
			n.run_while_halted   = s.run_while_halted;
			n.src_cnt  = s.src_cnt;
		end

		// address phase capture
		rd = hsel && hready && htrans[1];
		if (hready) begin
			n.a_valid = rd;
			n.a_write = hwrite;
			n.a_ok    = (haddr[31:9] == 23'h0) && (haddr[1:0] == 2'h0);
			n.a_idx   = haddr[8:2];
		end

		// read data from the post-write state, zero wait
		if (rd && !hwrite) begin
			case (haddr[8:2])
				`IDX_CTRL_A: n.rdata = {16'h0, n.ctrl_a};
				`IDX_CTRL_B: n.rdata = {16'h0, n.ctrl_b};
				`IDX_EVENT_OUTPUT_CONTROL: n.rdata = n.event_output_control;
				`IDX_IEN_CLR, `IDX_IEN_SET: n.rdata = {16'h0, n.inten};
				`IDX_FLAGS: n.rdata = {16'h0, n.flags};
				`IDX_DBG: n.rdata = {31'h0, n.run_while_halted};
				`IDX_BUSY: begin
					n.rdata          = 32'h0;
					n.rdata[`SB_EN]  = n.en_pend;
					n.rdata[`SB_FC]  = n.fc_pend;
					n.rdata[`SB_CNT] = n.cnt_pend;
				end
				`IDX_RATE_CORRECTION: n.rdata = {24'h0, n.rate_correction};
				`IDX_COUNT: n.rdata = n.count;
				`IDX_COMP0: n.rdata = n.comp0;
				`IDX_COMP1: n.rdata = {16'h0, n.comp1};
				`IDX_MASK: n.rdata = {29'h0, n.mask};
				`IDX_GP0: n.rdata = n.gp0;
				`IDX_GP1: n.rdata = n.gp1;
				`IDX_STAMP: n.rdata = n.stamp;
				default: n.rdata = 32'h0;
			endcase
			if (haddr[31:9] != 23'h0) begin
				n.rdata = 32'h0;
			end
		end

		// RULE18: enabled flag drives irq
		// RULE2: wake on enabled event or pin
		n.rdy  = 1'b1;
		n.irq  = |(n.flags & n.inten);
		n.wake = n.irq || wake_in;
		// RULE3: event outputs gated per bit
		n.ev[7:0] = evs[7:0] & n.event_output_control[7:0];
		n.ev[8]   = evs[`EV_CMP0] & n.event_output_control[`EV_CMP0];
		n.ev[9]   = evs[`EV_CMP1] & n.event_output_control[`EV_CMP1];
		n.ev[10]  = evs[`EV_TAMP] & n.event_output_control[`EV_TAMP];
		n.ev[11]  = evs[`EV_OVF] & n.event_output_control[`EV_OVF];
	end

	// one register for all state; hreadyout high even in reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s     <= '0;
			s.rdy <= 1'b1;
		end else begin
			s <= n;
		end
	end
endmodule : real_time_counter_calendar
`default_nettype wire

// *** verilog/rtc_params.svh ***
// rtc_params.svh: offsets, field positions and timing counts of the counter
// assumes inclusion by bare name from the design files
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// source clock derived from hclk
`define HCLK_FREQ_HZ 100000000
`define SRC_FREQ_HZ  32768
`define SRC_DIV      (`HCLK_FREQ_HZ / `SRC_FREQ_HZ)

// register indices, byte address is four times the index
`define IDX_CTRL_A   7'h00
`define IDX_CTRL_B   7'h02
`define IDX_EVENT_OUTPUT_CONTROL   7'h04
`define IDX_IEN_CLR  7'h08
`define IDX_IEN_SET  7'h0A
`define IDX_FLAGS    7'h0C
`define IDX_DBG      7'h0E
`define IDX_BUSY     7'h10
`define IDX_RATE_CORRECTION 7'h14
`define IDX_COUNT    7'h18
`define IDX_COMP0    7'h20
`define IDX_COMP1    7'h22
`define IDX_MASK     7'h24
`define IDX_GP0      7'h40
`define IDX_GP1      7'h44
`define IDX_STAMP    7'h64

// control_a fields
`define CA_SOFT_RESET   0
`define CA_EN      1
`define CA_MODE    2
`define CA_CLKREP  6
`define CA_MCLR    7
`define CA_PSC     8
`define CA_GP_RESET_ON_TAMPER  14
`define PSC_MAX    4'd10

// event / flag bit positions
`define EV_CMP0  8
`define EV_CMP1  9
`define EV_TAMP  14
`define EV_OVF   15
`define EV_TEI   16

// sync busy bits
`define SB_EN    1
`define SB_FC    2
`define SB_CNT   3

// correction
`define FC_SIGN  7
`define CORR_W   7

// calendar layout and limits
`define CAL_MIN_LSB  6
`define CAL_HR_LSB   12
`define CAL_DAY_LSB  17
`define CAL_MON_LSB  22
`define CAL_YR_LSB   26
`define CAL_SEC_MAX  6'd59
`define CAL_HR24_MAX 5'd23
`define CAL_HR12_TOP 4'd12
`define CAL_HR12_PM  4'd11
`define CAL_MON_MAX  4'd12
`define CAL_FEB      4'd2
`define CAL_APR      4'd4
`define CAL_JUN      4'd6
`define CAL_SEP      4'd9
`define CAL_NOV      4'd11
`define CAL_D28      5'd28
`define CAL_D29      5'd29
`define CAL_D30      5'd30
`define CAL_D31      5'd31

`endif

// *** verilog/rtc_pkg.sv ***
// rtc_pkg: types of the counter/calendar block
// assumes rtc_params.svh for all numeric constants
`default_nettype none
package rtc_pkg;

	typedef enum logic [1:0] {MODE_FULL_WIDTH_COUNT_MODE, MODE_COUNT16, MODE_CALENDAR, MODE_RSVD} mode_t;

	typedef struct packed {
		logic [15:0] ctrl_a;
		logic [15:0] ctrl_b;
		logic [31:0] event_output_control;
		logic [15:0] inten;
		logic [15:0] flags;
		logic        run_while_halted;
		logic [7:0]  rate_correction;
		logic [31:0] count;
		logic [31:0] comp0;
		logic [15:0] comp1;
		logic [2:0]  mask;
		logic [31:0] gp0;
		logic [31:0] gp1;
		logic [31:0] stamp;
		logic        cnt_pend;
		logic [31:0] cnt_new;
		logic        en_pend;
		logic        en_new;
		logic        fc_pend;
		logic [7:0]  fc_new;
		logic [11:0] src_cnt;
		logic [9:0]  psc;
		logic [6:0]  cw;
		logic [4:0]  tp0;
		logic [4:0]  tp1;
		logic [4:0]  tdb;
		logic        a_valid;
		logic        a_write;
		logic        a_ok;
		logic [6:0]  a_idx;
		logic        rdy;
		logic [31:0] rdata;
		logic        irq;
		logic        wake;
		logic [11:0] ev;
	} state_t;

endpackage : rtc_pkg
`default_nettype wire
